// ==== logic/rsec_en_if.sv ====
// Carrier between the register bank and one enable selector
`timescale 1ns/1ns
interface rsec_en_if;
  logic [2:0] seq_code;
  logic [1:0] en_field;
  logic [7:0] pin_sel;
  logic [7:0] pins;
  logic always_on_ok;
  logic boot_0;
  logic boot_25;
  logic boot_50;
  logic boot_done;
  logic enable;

  modport bank (
    output seq_code, en_field, pin_sel, pins, always_on_ok,
    output boot_0, boot_25, boot_50, boot_done,
    input enable
  );
  modport sel (
    input seq_code, en_field, pin_sel, pins, always_on_ok,
    input boot_0, boot_25, boot_50, boot_done,
    output enable
  );
endinterface

// ==== logic/rsec_enable_sel.sv ====
// Start-up sequencing and enable selection for one output
`timescale 1ns/1ns
module rsec_enable_sel
  import rsec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bank side
  rsec_en_if.sel en
);

  logic enable_q;
  logic enable_d;
  logic field_en;

  // ---------------------------------------------------------------
  // Sequencing decode
  // ---------------------------------------------------------------
  // pins ORed
  assign field_en = rsec_field_enable(en.en_field, en.pin_sel, en.pins);

  always_comb begin
    enable_d = 1'b0;
    case (rsec_seq_t'(en.seq_code))
      RSEC_SEQ_OFF: enable_d = 1'b0;
      // Selector for the switch is wired with always_on_ok low
      RSEC_SEQ_ALWAYS_ON: enable_d = en.always_on_ok;
      RSEC_SEQ_BOOT_0: enable_d = en.boot_0;
      RSEC_SEQ_BOOT_25: enable_d = en.boot_25;
      RSEC_SEQ_BOOT_50: enable_d = en.boot_50;
      RSEC_SEQ_REG_CTRL: enable_d = en.boot_done & field_en;
      default: enable_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  assign en.enable = enable_q;

endmodule

// ==== logic/rsec_map.svh ====
// Register offsets, field positions and reset values for the regulator block
`ifndef RSEC_MAP_SVH
`define RSEC_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RSEC_REG_B_ENABLE_ADDR 8'h55
`define RSEC_REG_B_CONFIG_ADDR 8'h56
`define RSEC_REG_B_VOLTAGE_ADDR 8'h57
`define RSEC_REG_B_PIN_SEL_ADDR 8'h58
`define RSEC_SW_A_ENABLE_ADDR 8'h59
`define RSEC_SW_A_CONFIG_ADDR 8'h5a
`define RSEC_SW_A_PIN_SEL_ADDR 8'h5b

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RSEC_SEQ_MSB 7
`define RSEC_SEQ_LSB 5
`define RSEC_EN_MSB 1
`define RSEC_EN_LSB 0
`define RSEC_CFG_SUPPLY_BIT 3
`define RSEC_CFG_ACT_DSC_BIT 2
`define RSEC_CFG_MODE_BIT 1
`define RSEC_CFG_LOWQ_BIT 1
`define RSEC_CFG_PSV_DSC_BIT 0
`define RSEC_VCODE_MSB 4
`define RSEC_REG_B_CFG_MASK 8'h0f
`define RSEC_SW_A_CFG_MASK 8'h07

// ---------------------------------------------------------------
// Reset values and voltage scale
// ---------------------------------------------------------------
`define RSEC_RST_EN_FIELD 2'h0
`define RSEC_RST_CFG 8'h00
`define RSEC_RST_VCODE 5'h00
`define RSEC_RST_PIN_SEL 8'h00
`define RSEC_VOUT_BASE_MV 13'h0384
`define RSEC_VOUT_STEP_MV 13'h0064

`endif

// ==== logic/rsec_pkg.sv ====
// Types and shared helpers for the regulator and switch enable block
package rsec_pkg;

  typedef enum logic [2:0] {
    RSEC_SEQ_OFF = 3'h0,
    RSEC_SEQ_ALWAYS_ON = 3'h1,
    RSEC_SEQ_BOOT_0 = 3'h2,
    RSEC_SEQ_BOOT_25 = 3'h3,
    RSEC_SEQ_BOOT_50 = 3'h4,
    RSEC_SEQ_RSVD_5 = 3'h5,
    RSEC_SEQ_RSVD_6 = 3'h6,
    RSEC_SEQ_REG_CTRL = 3'h7
  } rsec_seq_t;

  typedef enum logic [1:0] {
    RSEC_EN_OFF = 2'h0,
    RSEC_EN_ON = 2'h1,
    RSEC_EN_PINS = 2'h2,
    RSEC_EN_RSVD = 2'h3
  } rsec_en_field_t;

  // Enable requested by the register field, pins ORed when selected
  function automatic logic rsec_field_enable(
    input logic [1:0] field,
    input logic [7:0] pin_sel,
    input logic [7:0] pins
  );
    logic r;
    r = 1'b0;
    case (rsec_en_field_t'(field))
      RSEC_EN_ON: r = 1'b1;
      RSEC_EN_PINS: r = |(pin_sel & pins);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ==== logic/rsec_top.sv ====
// Register bank and enable logic for regulator_b and load_switch_a
`timescale 1ns/1ns
`include "rsec_map.svh"

module rsec_top
  import rsec_pkg::*;
#(
  parameter int NUM_PINS = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register access from the serial control engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Factory sequence codes and boot progress
  input wire logic [2:0] regulator_b_sequence_code,
  input wire logic [2:0] switch_a_sequence_code,
  input wire logic battery_present,
  input wire logic boot_at_0,
  input wire logic boot_at_25,
  input wire logic boot_at_50,
  input wire logic boot_done,
  // Power mode and protection
  input wire logic hard_reset_mode,
  input wire logic off_mode,
  input wire logic switch_a_prot_trip,
  // Control pins
  input wire logic [NUM_PINS-1:0] multipurpose_control_pin,
  // Regulator controls
  output logic regulator_b_enable,
  output logic regulator_b_switch_mode,
  output logic regulator_b_input_select,
  output logic regulator_b_active_discharge,
  output logic regulator_b_passive_discharge,
  output logic [4:0] regulator_b_voltage_code,
  output logic [12:0] regulator_b_voltage_mv,
  // Switch controls
  output logic switch_a_enable,
  output logic switch_a_active_discharge,
  output logic switch_a_passive_discharge
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [1:0] reg_b_en_q;
  logic [3:0] reg_b_cfg_q;
  logic [4:0] reg_b_vcode_q;
  logic [7:0] reg_b_pin_sel_q;
  logic [1:0] sw_a_en_q;
  logic [2:0] sw_a_cfg_q;
  logic [7:0] sw_a_pin_sel_q;
  logic mode_q;
  logic [NUM_PINS-1:0] pin_s1_q;
  logic [NUM_PINS-1:0] pin_s2_q;
  logic [NUM_PINS-1:0] pin_s3_q;
  logic [NUM_PINS-1:0] pin_q;
  logic off_mode_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [12:0] vout_q;
  logic rb_dsc_act_q;
  logic rb_dsc_psv_q;
  logic sw_dsc_act_q;
  logic sw_dsc_psv_q;
  logic sw_en_q;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire sel_rb_en = reg_addr == `RSEC_REG_B_ENABLE_ADDR;
  wire sel_rb_cfg = reg_addr == `RSEC_REG_B_CONFIG_ADDR;
  wire sel_rb_v = reg_addr == `RSEC_REG_B_VOLTAGE_ADDR;
  wire sel_rb_pin = reg_addr == `RSEC_REG_B_PIN_SEL_ADDR;
  wire sel_sw_en = reg_addr == `RSEC_SW_A_ENABLE_ADDR;
  wire sel_sw_cfg = reg_addr == `RSEC_SW_A_CONFIG_ADDR;
  wire sel_sw_pin = reg_addr == `RSEC_SW_A_PIN_SEL_ADDR;

  // reserved bits zero, sequence codes read only
  wire [7:0] rd_mux =
    sel_rb_en ? {regulator_b_sequence_code, 3'h0, reg_b_en_q} :
    sel_rb_cfg ? {4'h0, reg_b_cfg_q} :
    sel_rb_v ? {3'h0, reg_b_vcode_q} :
    sel_rb_pin ? reg_b_pin_sel_q :
    sel_sw_en ? {switch_a_sequence_code, 3'h0, sw_a_en_q} :
    sel_sw_cfg ? {5'h0, sw_a_cfg_q} :
    sel_sw_pin ? sw_a_pin_sel_q : 8'h00;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // only writable fields stored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_b_en_q <= `RSEC_RST_EN_FIELD;
      reg_b_cfg_q <= 4'(`RSEC_RST_CFG);
      reg_b_vcode_q <= `RSEC_RST_VCODE;
      reg_b_pin_sel_q <= `RSEC_RST_PIN_SEL;
      sw_a_en_q <= `RSEC_RST_EN_FIELD;
      sw_a_cfg_q <= 3'(`RSEC_RST_CFG);
      sw_a_pin_sel_q <= `RSEC_RST_PIN_SEL;
    end else if (reg_wr) begin
      if (sel_rb_en) reg_b_en_q <= reg_wdata[`RSEC_EN_MSB:`RSEC_EN_LSB];
      if (sel_rb_cfg) begin
        reg_b_cfg_q <= 4'(reg_wdata & `RSEC_REG_B_CFG_MASK);
      end
      if (sel_rb_v) reg_b_vcode_q <= reg_wdata[`RSEC_VCODE_MSB:0];
      if (sel_rb_pin) reg_b_pin_sel_q <= reg_wdata;
      if (sel_sw_en) sw_a_en_q <= reg_wdata[`RSEC_EN_MSB:`RSEC_EN_LSB];
      if (sel_sw_cfg) begin
        sw_a_cfg_q <= 3'(reg_wdata & `RSEC_SW_A_CFG_MASK);
      end
      if (sel_sw_pin) sw_a_pin_sel_q <= reg_wdata;
    end
  end

  // Read data registered, one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ---------------------------------------------------------------
  // Control pin synchroniser
  // ---------------------------------------------------------------
  // Pins are asynchronous; third stage filters a single-cycle glitch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end else begin
      pin_s1_q <= multipurpose_control_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) pin_q[i] <= pin_s3_q[i];
      end
    end
  end

  wire [7:0] pins8 = 8'(pin_q);

  // ---------------------------------------------------------------
  // Enable selectors
  // ---------------------------------------------------------------
  rsec_en_if rb_if();
  rsec_en_if sw_if();

  assign rb_if.seq_code = regulator_b_sequence_code;
  assign rb_if.en_field = reg_b_en_q;
  assign rb_if.pin_sel = reg_b_pin_sel_q;
  assign rb_if.pins = pins8;
  assign rb_if.always_on_ok = battery_present;
  assign rb_if.boot_0 = boot_at_0;
  assign rb_if.boot_25 = boot_at_25;
  assign rb_if.boot_50 = boot_at_50;
  assign rb_if.boot_done = boot_done;

  assign sw_if.seq_code = switch_a_sequence_code;
  assign sw_if.en_field = sw_a_en_q;
  assign sw_if.pin_sel = sw_a_pin_sel_q;
  assign sw_if.pins = pins8;
  // Code 001 is reserved for the switch, so it stays off
  assign sw_if.always_on_ok = 1'b0;
  assign sw_if.boot_0 = boot_at_0;
  assign sw_if.boot_25 = boot_at_25;
  assign sw_if.boot_50 = boot_at_50;
  assign sw_if.boot_done = boot_done;

  rsec_enable_sel u_rb_sel (
    .mclk(mclk),
    .rst(rst),
    .en(rb_if.sel)
  );

  rsec_enable_sel u_sw_sel (
    .mclk(mclk),
    .rst(rst),
    .en(sw_if.sel)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // trip only kills switch when protection on
  wire sw_prot_off = switch_a_prot_trip & ~sw_a_cfg_q[`RSEC_CFG_LOWQ_BIT];
  wire sw_en_d = sw_if.enable & ~sw_prot_off;
  wire off_entry = off_mode & ~off_mode_q;
  wire rb_en = rb_if.enable;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      off_mode_q <= 1'b0;
      vout_q <= `RSEC_VOUT_BASE_MV;
      rb_dsc_act_q <= 1'b0;
      rb_dsc_psv_q <= 1'b0;
      sw_dsc_act_q <= 1'b0;
      sw_dsc_psv_q <= 1'b0;
      sw_en_q <= 1'b0;
    end else begin
      // mode follows register only while disabled
      if (!rb_en) mode_q <= reg_b_cfg_q[`RSEC_CFG_MODE_BIT];
      off_mode_q <= off_mode;
      vout_q <= `RSEC_VOUT_BASE_MV + `RSEC_VOUT_STEP_MV *
                13'(reg_b_vcode_q);
      rb_dsc_act_q <= hard_reset_mode |
        (reg_b_cfg_q[`RSEC_CFG_ACT_DSC_BIT] & ~rb_en);
      rb_dsc_psv_q <= hard_reset_mode |
        (reg_b_cfg_q[`RSEC_CFG_PSV_DSC_BIT] & ~rb_en);
      sw_en_q <= sw_en_d;
      sw_dsc_act_q <= hard_reset_mode |
        (sw_a_cfg_q[`RSEC_CFG_ACT_DSC_BIT] & ~sw_en_d);
      sw_dsc_psv_q <= hard_reset_mode | off_entry |
        (sw_a_cfg_q[`RSEC_CFG_PSV_DSC_BIT] & ~sw_en_d);
    end
  end

  assign regulator_b_enable = rb_en;
  assign regulator_b_switch_mode = mode_q;
  assign regulator_b_input_select = reg_b_cfg_q[`RSEC_CFG_SUPPLY_BIT];
  assign regulator_b_active_discharge = rb_dsc_act_q;
  assign regulator_b_passive_discharge = rb_dsc_psv_q;
  assign regulator_b_voltage_code = reg_b_vcode_q;
  assign regulator_b_voltage_mv = vout_q;
  assign switch_a_enable = sw_en_q;
  assign switch_a_active_discharge = sw_dsc_act_q;
  assign switch_a_passive_discharge = sw_dsc_psv_q;

endmodule

// ==== verif/rsec_host_model.sv ====
// Host model driving the register port
`timescale 1ns/1ns
module rsec_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Idle lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ==== verif/rsec_top_props.sv ====
// Port-level checks on the regulator and switch register block
`timescale 1ns/1ns
module rsec_top_props
  import rsec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Status inputs
  input wire logic [2:0] regulator_b_sequence_code,
  input wire logic [2:0] switch_a_sequence_code,
  input wire logic hard_reset_mode,
  input wire logic off_mode,
  // Outputs
  input wire logic regulator_b_enable,
  input wire logic regulator_b_switch_mode,
  input wire logic regulator_b_input_select,
  input wire logic regulator_b_active_discharge,
  input wire logic regulator_b_passive_discharge,
  input wire logic [4:0] regulator_b_voltage_code,
  input wire logic [12:0] regulator_b_voltage_mv,
  input wire logic switch_a_enable,
  input wire logic switch_a_active_discharge,
  input wire logic switch_a_passive_discharge
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_unmapped_zero: assert property (reg_rd &&
    !(reg_addr inside {[8'h55:8'h5b]}) |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_supply_bit: assert property (
    $past(reg_wr && reg_addr == 8'h56, 2) && !$past(reg_wr)
    |-> regulator_b_input_select == $past(reg_wdata[3], 2))
    else $error("input select wrong");
  chk_volt_scale: assert property (
    $stable(regulator_b_voltage_code) [*2] |->
    regulator_b_voltage_mv == 13'h0384 + 13'h0064 * regulator_b_voltage_code)
    else $error("voltage scale wrong");
  // Latched mode must not move while the output is on
  chk_mode_held: assert property (
    regulator_b_enable && $past(regulator_b_enable)
    |-> $stable(regulator_b_switch_mode))
    else $error("mode changed while enabled");
  chk_sw_seq_off: assert property (
    (switch_a_sequence_code inside {3'h0, 3'h1, 3'h5, 3'h6}) [*4]
    |-> !switch_a_enable)
    else $error("switch on with off code");
  chk_reg_seq_off: assert property (
    (regulator_b_sequence_code inside {3'h0, 3'h5, 3'h6}) [*4]
    |-> !regulator_b_enable)
    else $error("regulator on with off code");
  chk_hard_dsc: assert property (
    hard_reset_mode [*3] |-> regulator_b_active_discharge &&
    regulator_b_passive_discharge && switch_a_active_discharge &&
    switch_a_passive_discharge)
    else $error("no discharge in hard reset");
  chk_off_entry: assert property (
    $rose(off_mode) |-> ##[1:2] switch_a_passive_discharge)
    else $error("no discharge entering off");
endmodule

bind rsec_top rsec_top_props i_props (
  .mclk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .reg_rvalid, .regulator_b_sequence_code, .switch_a_sequence_code,
  .hard_reset_mode, .off_mode, .regulator_b_enable,
  .regulator_b_switch_mode, .regulator_b_input_select,
  .regulator_b_active_discharge, .regulator_b_passive_discharge,
  .regulator_b_voltage_code, .regulator_b_voltage_mv, .switch_a_enable,
  .switch_a_active_discharge, .switch_a_passive_discharge
);

// ==== verif/tb.sv ====
// Self-checking bench for the regulator and switch register block
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] rseq = 3'h7;
  logic [2:0] sseq = 3'h7;
  // Boot flags: done, at 50, at 25, at 0, battery
  logic [4:0] boot = 5'h1f;
  logic [7:0] sexp;
  logic hrm = 1'b0;
  logic offm = 1'b0;
  logic trip = 1'b0;
  logic [7:0] pins = 8'h00;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, rvalid, ren, smode, isel, ract, rpsv, sen, sact, spsv;
  wire [4:0] vcode;
  wire [12:0] vmv;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] d;
  logic v;
  logic [7:0] msk [7] = '{8'he3, 8'h0f, 8'h1f, 8'hff, 8'he3, 8'h07, 8'hff};
  logic [7:0] ena [2] = '{8'h55, 8'h59};
  // Enable cases: expected, field, pins
  logic [11:0] ecase [7] = '{12'h0ff, 12'h900, 12'h3ff, 12'ha80, 12'ha01,
    12'h27e, 12'h200};

  always #4 mclk = ~mclk;

  rsec_host_model i_host (.mclk(mclk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
  rsec_top #(.NUM_PINS(8)) i_dut (.mclk(mclk), .rst(rst), .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .regulator_b_sequence_code(rseq),
    .switch_a_sequence_code(sseq), .battery_present(boot[0]),
    .boot_at_0(boot[1]), .boot_at_25(boot[2]), .boot_at_50(boot[3]),
    .boot_done(boot[4]), .hard_reset_mode(hrm), .off_mode(offm),
    .switch_a_prot_trip(trip), .multipurpose_control_pin(pins),
    .regulator_b_enable(ren), .regulator_b_switch_mode(smode),
    .regulator_b_input_select(isel), .regulator_b_active_discharge(ract),
    .regulator_b_passive_discharge(rpsv), .regulator_b_voltage_code(vcode),
    .regulator_b_voltage_mv(vmv), .switch_a_enable(sen),
    .switch_a_active_discharge(sact), .switch_a_passive_discharge(spsv));

  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic test_done();
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      rchk(8'(8'h55 + i), (i % 4 == 0) ? 8'he0 : 8'h00);
      i_host.wr(8'(8'h55 + i), 8'hff);
      rchk(8'(8'h55 + i), msk[i]);
      i_host.wr(8'(8'h55 + i), 8'h00);
    end
    i_host.wr(8'h70, 8'hff);
    rchk(8'h70, 8'h00);
    i_host.wr(8'h57, 8'h1f);
    settle();
    `CHK(vmv, 13'h0fa0)
    i_host.wr(8'h57, 8'h05);
    settle();
    `CHK({vcode, vmv}, {5'h05, 13'h0578})
    for (int j = 0; j < 2; j++) begin
      i_host.wr(8'(ena[j] + 3 - j), 8'h81);
      for (int k = 0; k < 7; k++) begin
        i_host.wr(ena[j], {6'h00, ecase[k][9:8]});
        pins = ecase[k][7:0];
        settle();
        `CHK(j ? sen : ren, ecase[k][11])
      end
      pins = 8'h00;
    end
    i_host.wr(8'h55, 8'h01);
    i_host.wr(8'h59, 8'h01);
    // One flag at a time, so a swapped boot decode shows up
    for (int b = 0; b < 6; b++) begin
      boot = (b < 5) ? 5'(1 << b) : 5'h00;
      sexp = {boot[4], 2'b00, boot[3:1], 2'b00};
      for (int c = 0; c < 8; c++) begin
        rseq = c[2:0];
        sseq = c[2:0];
        settle();
        `CHK(sen, sexp[c])
        `CHK(ren, sexp[c] | (c == 1 && boot[0]))
      end
    end
    boot = 5'h1f;
    trip = 1'b1;
    settle();
    `CHK(sen, 1'b0)
    i_host.wr(8'h5a, 8'h02);
    settle();
    `CHK(sen, 1'b1)
    trip = 1'b0;
    i_host.wr(8'h5a, 8'h05);
    i_host.wr(8'h56, 8'h05);
    settle();
    `CHK({sact, spsv, ract, rpsv}, 4'h0)
    i_host.wr(8'h55, 8'h00);
    i_host.wr(8'h59, 8'h00);
    settle();
    `CHK({sact, spsv, ract, rpsv}, 4'hf)
    i_host.wr(8'h5a, 8'h00);
    i_host.wr(8'h56, 8'h00);
    settle();
    `CHK({sact, spsv, ract, rpsv}, 4'h0)
    hrm = 1'b1;
    settle();
    `CHK({sact, spsv, ract, rpsv}, 4'hf)
    hrm = 1'b0;
    settle();
    offm = 1'b1;
    @(negedge mclk);
    `CHK(spsv, 1'b1)
    settle();
    `CHK(spsv, 1'b0)
    offm = 1'b0;
    i_host.wr(8'h55, 8'h01);
    i_host.wr(8'h56, 8'h0a);
    settle();
    `CHK({smode, isel}, 2'b01)
    i_host.wr(8'h55, 8'h00);
    settle();
    `CHK({smode, isel}, 2'b11)
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    rchk(8'h56, 8'h00);
    test_done();
  end

  // Whole sequence needs well under 3000 cycles
  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule
